/* File: common/timer_prescaler_pkg.sv */
package timer_prescaler_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_FLAGS = 8'h0b;
   localparam logic [7:0] IDX_MASK = 8'h0c;
   localparam logic [7:0] IDX_GENERAL = 8'h23;
   localparam logic [7:0] IDX_CLOCK_SELECT = 8'h30;
   localparam int ADDR_WIDTH = 12;

   // Flag and enable bit positions, shared by mask and flag registers
   localparam int BIT_CAPTURE = 5;
   localparam int BIT_COMPARE_B = 2;
   localparam int BIT_COMPARE_A = 1;
   localparam int BIT_OVERFLOW = 0;
   localparam logic [7:0] IRQ_BITS = 8'h27;

   // General control fields
   localparam int BIT_SYNC_HOLD = 7;
   localparam int BIT_PRESCALER_RESET = 0;

   // Clock select register: timer 1 field low, timer 0 field above it
   localparam int CS1_LSB = 0;
   localparam int CS0_LSB = 3;
   localparam int CS_WIDTH = 3;

   localparam logic [7:0] RESET_FLAGS = 8'h00;
   localparam logic [7:0] RESET_MASK = 8'h00;
   localparam logic [7:0] RESET_GENERAL = 8'h00;
   localparam logic [7:0] RESET_CLOCK_SELECT = 8'h00;

   typedef enum logic [2:0] {
      CS_STOPPED = 3'b000,
      CS_DIRECT = 3'b001,
      CS_DIV8 = 3'b010,
      CS_DIV64 = 3'b011,
      CS_DIV256 = 3'b100,
      CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } clock_select_type;

   // Prescaler tap divisors as log2
   localparam int LOG_DIV8 = 3;
   localparam int LOG_DIV64 = 6;
   localparam int LOG_DIV256 = 8;
   localparam int LOG_DIV1024 = 10;
endpackage

/* File: rtl/timer_prescaler_irq_flags.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R1 - Capture request needs capture enable bit 5, global enable and capture flag.
// R2 - Compare B request needs enable bit 2, global enable and its flag.
// R3 - Compare A request needs enable bit 1, global enable and its flag.
// R4 - Overflow request needs enable bit 0, global enable and overflow flag.
// R5 - Bits 7:6 and 4:3 of mask and flag registers read zero.
// R6 - Capture event sets capture flag; with capture as top, reaching top does.
// R7 - Vector execution or writing one clears each of the four flags.
// R8 - Compare flags set in the timer clock cycle after counter equals compare.
// R9 - Forced compare strobes never touch the compare flags.
// R10 - Overflow flag set on overflow point supplied by the counter core.
// R11 - One prescaler shared, each timer picks its own tap.
// R12 - Clock select 1 counts every system clock.
// R13 - Prescaler taps divide by 8, 64, 256 and 1024.
// R14 - Prescaler runs free, ignoring clock selects.
// R15 - External pin synchronised; select 7 counts rising, 6 falling edges.
// R16 - External edge reaches the counter within 2.5 to 3.5 cycles.
// R17 - Outside party keeps pin stable a cycle around enabling the input.
// R18 - External clock half periods exceed one system clock cycle.
// R19 - External clock never passes through prescaler dividers.
// R20 - Sync hold mode keeps prescaler reset; clearing mode clears reset.
// R21 - Prescaler reset bit resets prescaler, self clears unless hold mode.
// R22 - Capture pin edge per edge select copies counter into capture register.
// R23 - Writing zero leaves flags; set wins over a same cycle clear.
module timer_prescaler_irq_flags #(
   parameter int PRESCALE_WIDTH = 10
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [timer_prescaler_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_enable,
   input wire logic [15:0] wide_counter,
   input wire logic capture_input_pin,
   input wire logic capture_edge_select,
   input wire logic capture_is_top,
   input wire logic counter_at_top,
   input wire logic compare_a_equal,
   input wire logic compare_b_equal,
   input wire logic force_compare_a,
   input wire logic force_compare_b,
   input wire logic overflow_event,
   input wire logic ack_capture,
   input wire logic ack_compare_b,
   input wire logic ack_compare_a,
   input wire logic ack_overflow,
   input wire logic external_count_pin,
   output logic capture_irq,
   output logic compare_b_irq,
   output logic compare_a_irq,
   output logic overflow_irq,
   output logic timer0_tick,
   output logic timer1_tick,
   output logic timers_halted,
   output logic [15:0] capture_register
);

   if (PRESCALE_WIDTH < timer_prescaler_pkg::LOG_DIV1024) begin : g_bad_width
      $error("Prescaler too narrow for the largest tap");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and APB decode

   logic [7:0] timer1_interrupt_flags;
   logic [7:0] timer1_interrupt_mask;
   logic sync_hold_mode;
   logic prescaler_reset_bit;
   logic [7:0] clock_select;
   logic [PRESCALE_WIDTH-1:0] prescaler;
   logic [2:0] ext_sync;
   logic [2:0] cap_sync;

   wire [9:0] word_index = paddr[11:2];
   wire setup = psel && !penable;
   wire write_access = psel && penable && pwrite && pready;
   wire hit_flags = word_index == {2'b00, timer_prescaler_pkg::IDX_FLAGS};
   wire hit_mask = word_index == {2'b00, timer_prescaler_pkg::IDX_MASK};
   wire hit_general = word_index == {2'b00, timer_prescaler_pkg::IDX_GENERAL};
   wire hit_select = word_index == {2'b00, timer_prescaler_pkg::IDX_CLOCK_SELECT};
   wire mapped = hit_flags || hit_mask || hit_general || hit_select;
   wire [7:0] general_view = {sync_hold_mode, 6'b00_0000, prescaler_reset_bit};

   // R5 - reserved bits zero
   wire [7:0] read_byte = hit_flags ? (timer1_interrupt_flags & timer_prescaler_pkg::IRQ_BITS) :
                          hit_mask ? (timer1_interrupt_mask & timer_prescaler_pkg::IRQ_BITS) :
                          hit_general ? general_view :
                          hit_select ? clock_select : 8'h00;

   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup) begin
            prdata <= {24'h00_0000, read_byte};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         timer1_interrupt_mask <= timer_prescaler_pkg::RESET_MASK;
         clock_select <= timer_prescaler_pkg::RESET_CLOCK_SELECT;
      end else begin
         if (write_access && hit_mask) begin
            timer1_interrupt_mask <= pwdata[7:0] & timer_prescaler_pkg::IRQ_BITS;
         end
         if (write_access && hit_select) begin
            clock_select <= {2'b00, pwdata[5:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler reset and synchronisation hold

   wire general_write = write_access && hit_general;

   // R20 R21 - reset bit kept only in hold mode
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_hold_mode <= timer_prescaler_pkg::RESET_GENERAL[timer_prescaler_pkg::BIT_SYNC_HOLD];
         prescaler_reset_bit <= timer_prescaler_pkg::RESET_GENERAL[timer_prescaler_pkg::BIT_PRESCALER_RESET];
      end else if (general_write) begin
         sync_hold_mode <= pwdata[timer_prescaler_pkg::BIT_SYNC_HOLD];
         prescaler_reset_bit <= pwdata[timer_prescaler_pkg::BIT_PRESCALER_RESET]
                                && pwdata[timer_prescaler_pkg::BIT_SYNC_HOLD];
      end else if (!sync_hold_mode) begin
         prescaler_reset_bit <= 1'b0;
      end
   end

   // A write of the reset bit without hold mode still resets for one cycle
   wire reset_pulse = general_write && pwdata[timer_prescaler_pkg::BIT_PRESCALER_RESET];
   wire prescaler_clear = prescaler_reset_bit || reset_pulse;
   wire hold = sync_hold_mode && prescaler_reset_bit;

   // R14 - free running counter, clock selects never reach it
   always_ff @(posedge clock) begin
      if (rst || prescaler_clear) begin
         prescaler <= '0;
      end else begin
         prescaler <= prescaler + 1'b1;
      end
   end

   function automatic logic tap_reached(input logic [PRESCALE_WIDTH-1:0] count, input int log_div);
      logic [PRESCALE_WIDTH-1:0] low_mask;
      low_mask = PRESCALE_WIDTH'((1 << log_div) - 1);
      return (count & low_mask) == low_mask;
   endfunction

   // R13 - four taps from the shared prescaler
   wire tap8 = tap_reached(prescaler, timer_prescaler_pkg::LOG_DIV8);
   wire tap64 = tap_reached(prescaler, timer_prescaler_pkg::LOG_DIV64);
   wire tap256 = tap_reached(prescaler, timer_prescaler_pkg::LOG_DIV256);
   wire tap1024 = tap_reached(prescaler, timer_prescaler_pkg::LOG_DIV1024);

   ////////////////////////////////////////////////////////////////////////////
   // External clock pin

   // R15 - two flop synchroniser, third flop for edge detect
   always_ff @(posedge clock) begin
      if (rst) begin
         ext_sync <= 3'b000;
         cap_sync <= 3'b000;
      end else begin
         ext_sync <= {ext_sync[1:0], external_count_pin};
         cap_sync <= {cap_sync[1:0], capture_input_pin};
      end
   end

   wire ext_rise = ext_sync[1] && !ext_sync[2];
   wire ext_fall = !ext_sync[1] && ext_sync[2];

   // R11 R12 R19 - tap choice per timer; external edges bypass the dividers
   function automatic logic select_tick(input logic [2:0] cs, input logic t8, input logic t64,
                                        input logic t256, input logic t1024, input logic rise,
                                        input logic fall);
      timer_prescaler_pkg::clock_select_type sel;
      logic tick;
      sel = timer_prescaler_pkg::clock_select_type'(cs);
      case (sel)
         timer_prescaler_pkg::CS_STOPPED: tick = 1'b0;
         timer_prescaler_pkg::CS_DIRECT: tick = 1'b1;
         timer_prescaler_pkg::CS_DIV8: tick = t8;
         timer_prescaler_pkg::CS_DIV64: tick = t64;
         timer_prescaler_pkg::CS_DIV256: tick = t256;
         timer_prescaler_pkg::CS_DIV1024: tick = t1024;
         timer_prescaler_pkg::CS_EXT_FALL: tick = fall;
         timer_prescaler_pkg::CS_EXT_RISE: tick = rise;
         default: tick = 1'b0;
      endcase
      return tick;
   endfunction

   wire [2:0] cs1 = clock_select[timer_prescaler_pkg::CS1_LSB +: timer_prescaler_pkg::CS_WIDTH];
   wire [2:0] cs0 = clock_select[timer_prescaler_pkg::CS0_LSB +: timer_prescaler_pkg::CS_WIDTH];
   wire next_tick1 = !hold && select_tick(cs1, tap8, tap64, tap256, tap1024, ext_rise, ext_fall);
   wire next_tick0 = !hold && select_tick(cs0, tap8, tap64, tap256, tap1024, ext_rise, ext_fall);

   // R16 - tick registered once after the edge detector
   always_ff @(posedge clock) begin
      if (rst) begin
         timer0_tick <= 1'b0;
         timer1_tick <= 1'b0;
         timers_halted <= 1'b0;
      end else begin
         timer0_tick <= next_tick0;
         timer1_tick <= next_tick1;
         timers_halted <= hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture register

   wire cap_edge = capture_edge_select ? (cap_sync[1] && !cap_sync[2]) : (!cap_sync[1] && cap_sync[2]);
   // Capture pin is disconnected while the capture register serves as top
   wire capture_event = cap_edge && !capture_is_top;

   // R22 - copy counter on the selected edge
   always_ff @(posedge clock) begin
      if (rst) begin
         capture_register <= 16'h0000;
      end else if (capture_event) begin
         capture_register <= wide_counter;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt flags

   // R6 - capture edge, or top when capture register is top
   wire set_capture = capture_event || (capture_is_top && counter_at_top && timer1_tick);
   // R8 R9 - match seen at a timer clock sets the flag; forced strobes ignored
   wire set_compare_a = compare_a_equal && timer1_tick;
   wire set_compare_b = compare_b_equal && timer1_tick;
   // R10 - overflow point comes from the counter core
   wire set_overflow = overflow_event;

   wire [7:0] flag_set = {2'b00, set_capture, 2'b00, set_compare_b, set_compare_a, set_overflow};
   wire [7:0] flag_ack = {2'b00, ack_capture, 2'b00, ack_compare_b, ack_compare_a, ack_overflow};
   wire [7:0] flag_clear = flag_ack | ((write_access && hit_flags) ? pwdata[7:0] : 8'h00);

   genvar i;
   for (i = 0; i < 8; i++) begin : g_flag
      if (timer_prescaler_pkg::IRQ_BITS[i]) begin : g_used
         // R7 R23 - one clears, zero leaves, set wins
         always_ff @(posedge clock) begin
            if (rst) begin
               timer1_interrupt_flags[i] <= timer_prescaler_pkg::RESET_FLAGS[i];
            end else begin
               timer1_interrupt_flags[i] <= flag_set[i] || (timer1_interrupt_flags[i] && !flag_clear[i]);
            end
         end
      end else begin : g_unused
         assign timer1_interrupt_flags[i] = 1'b0;
      end
   end

   wire [7:0] request = timer1_interrupt_flags & timer1_interrupt_mask & {8{global_irq_enable}};

   // R1 R2 R3 R4 - request needs enable, global enable and flag
   always_ff @(posedge clock) begin
      if (rst) begin
         capture_irq <= 1'b0;
         compare_b_irq <= 1'b0;
         compare_a_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end else begin
         capture_irq <= request[timer_prescaler_pkg::BIT_CAPTURE];
         compare_b_irq <= request[timer_prescaler_pkg::BIT_COMPARE_B];
         compare_a_irq <= request[timer_prescaler_pkg::BIT_COMPARE_A];
         overflow_irq <= request[timer_prescaler_pkg::BIT_OVERFLOW];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_capture_irq;
      capture_irq |-> $past(global_irq_enable) && $past(timer1_interrupt_mask[5]) && $past(timer1_interrupt_flags[5]);
   endproperty
   a_capture_irq: assert property (p_capture_irq) else $error("Capture request without its causes"); // R1

   property p_compare_b_irq;
      compare_b_irq |-> $past(global_irq_enable) && $past(timer1_interrupt_mask[2]) && $past(timer1_interrupt_flags[2]);
   endproperty
   a_compare_b_irq: assert property (p_compare_b_irq) else $error("Compare B request without causes"); // R2

   property p_compare_a_irq;
      global_irq_enable && timer1_interrupt_mask[1] && timer1_interrupt_flags[1] |=> compare_a_irq;
   endproperty
   a_compare_a_irq: assert property (p_compare_a_irq) else $error("Compare A request missing"); // R3

   property p_overflow_irq;
      !global_irq_enable |=> !overflow_irq;
   endproperty
   a_overflow_irq: assert property (p_overflow_irq) else $error("Overflow request while disabled"); // R4

   property p_reserved_zero;
      pready && !pwrite && (hit_flags || hit_mask) |-> (prdata[7:0] & 8'hd8) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero"); // R5

   property p_set_wins;
      set_compare_a && flag_clear[1] |=> timer1_interrupt_flags[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Set lost against clear"); // R23

   property p_clear_by_one;
      !flag_set[0] && flag_clear[0] |=> !timer1_interrupt_flags[0];
   endproperty
   a_clear_by_one: assert property (p_clear_by_one) else $error("Overflow flag not cleared"); // R7

   property p_force_ignored;
      force_compare_b && !set_compare_b && !timer1_interrupt_flags[2] |=> !timer1_interrupt_flags[2];
   endproperty
   a_force_ignored: assert property (p_force_ignored) else $error("Forced compare set a flag"); // R9

   property p_direct_clock;
      cs1 == 3'b001 && !hold |=> timer1_tick;
   endproperty
   a_direct_clock: assert property (p_direct_clock) else $error("Direct clock missed a tick"); // R12

   property p_reset_self_clears;
      general_write && pwdata[timer_prescaler_pkg::BIT_PRESCALER_RESET] && !pwdata[timer_prescaler_pkg::BIT_SYNC_HOLD]
         |=> !prescaler_reset_bit && prescaler == '0;
   endproperty
   a_reset_self_clears: assert property (p_reset_self_clears) else $error("Reset bit stuck"); // R21

   property p_hold_halts;
      hold |=> !timer0_tick && !timer1_tick && prescaler == '0;
   endproperty
   a_hold_halts: assert property (p_hold_halts) else $error("Timers advanced in hold"); // R20

   property p_ext_rise;
      cs1 == 3'b111 && !hold && $rose(ext_sync[1]) |=> timer1_tick;
   endproperty
   a_ext_rise: assert property (p_ext_rise) else $error("Rising edge not counted"); // R15

   c_capture: cover property (capture_event ##1 timer1_interrupt_flags[5]);
   c_hold_release: cover property (hold ##1 !hold);
   c_div8: cover property (cs1 == 3'b010 && timer1_tick);
   c_force_a: cover property (force_compare_a && !set_compare_a);
endmodule

/* File: tb/ext_clock_source.sv */
`timescale 1ns/1ps
module ext_clock_source (
   input wire logic clock,
   input wire logic start,
   input wire logic [3:0] half_cycles,
   input wire logic [7:0] n_toggles,
   output logic pin,
   output logic busy
);
   logic [3:0] cnt;
   logic [7:0] left;

   initial begin
      pin = 1'b0;
      busy = 1'b0;
      cnt = 4'h0;
      left = 8'h00;
   end

   // pin held still between bursts, half period of two or more cycles
   always @(posedge clock) begin
      if (start) begin
         busy <= 1'b1;
         left <= n_toggles;
         cnt <= half_cycles;
      end else if (busy) begin
         if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
         end else if (left == 8'h00) begin
            busy <= 1'b0;
         end else begin
            pin <= ~pin;
            left <= left - 8'h01;
            cnt <= half_cycles;
         end
      end
   end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   localparam int LIMIT = 40000;
   localparam logic [7:0] FLG = timer_prescaler_pkg::IDX_FLAGS;
   localparam logic [7:0] MSK = timer_prescaler_pkg::IDX_MASK;
   localparam logic [7:0] GEN = timer_prescaler_pkg::IDX_GENERAL;
   localparam logic [7:0] CSL = timer_prescaler_pkg::IDX_CLOCK_SELECT;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, mask;
   logic global_irq_enable, capture_input_pin, capture_edge_select, capture_is_top, counter_at_top;
   logic compare_a_equal, compare_b_equal, force_compare_a, force_compare_b, overflow_event;
   logic ack_capture, ack_compare_b, ack_compare_a, ack_overflow, external_count_pin;
   logic capture_irq, compare_b_irq, compare_a_irq, overflow_irq, timer0_tick, timer1_tick, timers_halted;
   logic [15:0] wide_counter, capture_register, wc;
   logic ext_start, ext_busy;
   logic [3:0] ext_half;
   logic [7:0] ext_toggles;
   int miscompares, n_tests, seed, cycles, n0, n1, a0, a1, t0, w, nd;

   timer_prescaler_irq_flags i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_irq_enable(global_irq_enable), .wide_counter(wide_counter), .capture_input_pin(capture_input_pin),
      .capture_edge_select(capture_edge_select), .capture_is_top(capture_is_top), .counter_at_top(counter_at_top),
      .compare_a_equal(compare_a_equal), .compare_b_equal(compare_b_equal), .force_compare_a(force_compare_a),
      .force_compare_b(force_compare_b), .overflow_event(overflow_event), .ack_capture(ack_capture),
      .ack_compare_b(ack_compare_b), .ack_compare_a(ack_compare_a), .ack_overflow(ack_overflow),
      .external_count_pin(external_count_pin), .capture_irq(capture_irq), .compare_b_irq(compare_b_irq),
      .compare_a_irq(compare_a_irq), .overflow_irq(overflow_irq), .timer0_tick(timer0_tick),
      .timer1_tick(timer1_tick), .timers_halted(timers_halted), .capture_register(capture_register));

   ext_clock_source i_ext (.clock(clock), .start(ext_start), .half_cycles(ext_half), .n_toggles(ext_toggles),
      .pin(external_count_pin), .busy(ext_busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h00_0000, wd};
      @(posedge clock);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge clock);
         w++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_tick();
      w = 0;
      do begin
         @(posedge clock);
         w++;
      end while (timer1_tick !== 1'b1 && w < 2100);
   endtask

   function automatic int tap_div(input int i);
      case (i)
         0: return 8;
         1: return 64;
         2: return 256;
         default: return 1024;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (timer0_tick === 1'b1) n0 <= n0 + 1;
      if (timer1_tick === 1'b1) n1 <= n1 + 1;
      if (cycles >= LIMIT) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, global_irq_enable, capture_input_pin, capture_edge_select} = '0;
      {capture_is_top, counter_at_top, compare_a_equal, compare_b_equal, force_compare_a, force_compare_b} = '0;
      {overflow_event, ack_capture, ack_compare_b, ack_compare_a, ack_overflow, wide_counter} = '0;
      {ext_start, ext_half, ext_toggles, miscompares, n_tests, cycles, n0, n1} = '0;
      seed = 12;
      rst = 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0000);
      apb(1'b0, GEN, 8'h00); chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h3f, 8'h00); chk({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, FLG, 8'hff); apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0000);
      apb(1'b1, CSL, 8'h01);
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         mask = (k == 0) ? 32'h0000_00ff : $random(seed);
         apb(1'b1, MSK, mask[7:0]); apb(1'b0, MSK, 8'h00); chk(rd, mask & 32'h0000_0027);
         wc = $random(seed);
         @(posedge clock);
         global_irq_enable <= (k != 1);
         {force_compare_a, force_compare_b} <= 2'h3;
         @(posedge clock);
         {force_compare_a, force_compare_b} <= 2'h0;
         repeat (3) @(posedge clock);
         apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0000);
         @(posedge clock);
         {overflow_event, compare_a_equal, compare_b_equal} <= 3'h7;
         wide_counter <= wc;
         capture_edge_select <= ~capture_input_pin;
         capture_input_pin <= ~capture_input_pin;
         @(posedge clock);
         {overflow_event, compare_a_equal, compare_b_equal} <= 3'h0;
         repeat (8) @(posedge clock);
         apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0027);
         chk(capture_register, wc);
         chk({capture_irq, compare_b_irq, compare_a_irq, overflow_irq},
             (k != 1) ? {mask[5], mask[2], mask[1], mask[0]} : 4'h0);
         apb(1'b1, FLG, 8'h00); apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0027);
         apb(1'b1, FLG, 8'h05); apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0022);
         @(posedge clock);
         {ack_capture, ack_compare_a, overflow_event, ack_overflow} <= 4'hf;
         @(posedge clock);
         {ack_capture, ack_compare_a, overflow_event, ack_overflow} <= 4'h0;
         apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0001);
         apb(1'b1, FLG, 8'h01);
         repeat (2) @(posedge clock);
         chk({capture_irq, compare_b_irq, compare_a_irq, overflow_irq}, 4'h0);
      end
      @(posedge clock);
      capture_is_top <= 1'b1;
      counter_at_top <= 1'b1;
      wide_counter <= ~wc;
      capture_edge_select <= ~capture_input_pin;
      capture_input_pin <= ~capture_input_pin;
      @(posedge clock);
      counter_at_top <= 1'b0;
      repeat (8) @(posedge clock);
      apb(1'b0, FLG, 8'h00); chk(rd, 32'h0000_0020);
      chk(capture_register, wc);
      apb(1'b1, FLG, 8'hff);
      $display("test flags done");
      apb(1'b1, CSL, 8'h11);
      // Let the old selects drain so the window holds whole tap periods
      repeat (4) @(posedge clock);
      a0 = n0;
      a1 = n1;
      repeat (512) @(posedge clock);
      chk(n0 - a0, 64);
      chk(n1 - a1, 512);
      apb(1'b1, GEN, 8'h81); apb(1'b0, GEN, 8'h00); chk(rd, 32'h0000_0081);
      chk(timers_halted, 1);
      a1 = n1;
      repeat (20) @(posedge clock);
      chk(n1 - a1, 0);
      apb(1'b1, GEN, 8'h00); apb(1'b0, GEN, 8'h00); chk(rd, 32'h0000_0000);
      chk(timers_halted, 0);
      apb(1'b1, GEN, 8'h01); apb(1'b0, GEN, 8'h00); chk(rd, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         nd = tap_div(i);
         apb(1'b1, CSL, 8'h00);
         apb(1'b1, CSL, 8'(2 + i));
         t0 = cycles;
         wait_tick();
         chk((cycles - t0) >= 1 && (cycles - t0) <= nd + 1, 1);
         t0 = cycles;
         wait_tick();
         chk(cycles - t0, nd);
      end
      $display("test prescaler done");
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, CSL, s ? 8'h37 : 8'h3e);
         ext_half <= 4'h2 + 4'($unsigned($random(seed)) % 6);
         ext_toggles <= 8'h14;
         a0 = n0;
         a1 = n1;
         @(posedge clock);
         ext_start <= 1'b1;
         @(posedge clock);
         ext_start <= 1'b0;
         w = 0;
         do begin
            @(posedge clock);
            w++;
         end while (ext_busy !== 1'b0 && w < 400);
         repeat (6) @(posedge clock);
         chk(n1 - a1, 10);
         chk(n0 - a0, 10);
      end
      apb(1'b1, CSL, 8'h00);
      $display("test external clock done");
      stop_test();
   end
endmodule
